// ==== rtl/xlf_reprogram_ctrl.sv ====
// frequency reprogramming control: register file, divider check, calibration
// ****************
// What this block does
// - a move of more than 1000 ppm is a large change that needs a calibration to set a new center.
// - the low-speed divider only divides by 1, 2, 4, 8, 16 or 32.
// - low-speed divider code zero means divide by one.
// - the output is forced off when the divider product leaves the floor to ceiling band.
// - writing one to the calibrate bit starts a calibration and the bit always reads zero.
// - calibration never starts by itself, only from the calibrate bit.
// - holding the output enable bit clear hides glitches until settling is over.
// - settling ends at most 10 ms after calibration starts.
// - new multiplier values take effect only when the upper integer register is written.
// - register 0 holds the first loop value in bits 7:4 and the second in bits 3:0.
// ****************
`timescale 1ns/1ps
module xlf_reprogram_ctrl
    import xlf_pkg::*;
#(
    parameter int SETTLE_CYCLES = XLF_SETTLE_CYCLES,
    parameter logic [7:0] PRODUCT_FLOOR = 8'(XLF_FLOOR_DEFAULT),
    parameter logic [7:0] PRODUCT_CEIL = 8'(XLF_CEIL_DEFAULT),
    parameter logic [6:0] DEV_ADDR = xlf_pkg::XLF_DEV_ADDR_DEFAULT
)
(
    input wire logic ref_clk_in,               // 40 MHz system clock
    input wire logic rst_in,                   // async reset, active high
    input wire logic scl_clk_in,               // serial clock from host
    input wire logic sda_in,                   // data line level
    output logic sda_out,                      // data line drive value
    output logic sda_oe_out,                   // data line drive enable
    output logic [8:0] m_int_out,              // active multiplier integer
    output logic [28:0] m_frac_out,            // active multiplier fraction
    output logic [9:0] high_speed_divider_out, // high-speed divide value
    output logic [5:0] low_speed_ratio_out,    // low-speed divide ratio
    output logic [3:0] loop_comp_first_out,    // first loop value
    output logic [3:0] loop_comp_second_out,   // second loop value
    output logic calibrating_out,              // calibration and settling busy
    output logic clk_enable_out                // synthesizer output gate
);
    import xlf_pkg::*;

    // ****************
    // helpers
    // ****************
    function automatic logic [5:0] xlf_ls_ratio(input logic [2:0] code);
        logic [2:0] c;
        c = (code > XLF_LS_MAX_CODE) ? XLF_LS_MAX_CODE : code;
        return 6'h01 << c;
    endfunction : xlf_ls_ratio

    function automatic logic xlf_in_band(input logic [15:0] prod);
        return (prod >= 16'(PRODUCT_FLOOR)) && (prod <= 16'(PRODUCT_CEIL));
    endfunction : xlf_in_band

    logic scl_m_r, scl_s_r, sda_m_r, sda_s_r, scl_d_r, sda_d_r;
    logic wr_tgl_m_r, wr_tgl_s_r, wr_tgl_d_r;
    logic rd_tgl_m_r, rd_tgl_s_r, rd_tgl_d_r;
    logic frame_rst_r;
    logic link_sda_oe;
    logic link_wr_tgl;
    logic [7:0] link_wr_byte;
    logic link_wr_ptr;
    logic link_rd_tgl;
    logic wr_evt, rd_evt, reg_wr;
    logic [7:0] ptr_r;
    logic [7:0] rd_byte_r;
    logic [7:0] loop_r, frac0_r, frac1_r, frac2_r, intlo_r, inthi_r, hslo_r, divhi_r;
    logic oe_r;
    logic [31:0] cal_cnt_r;
    logic [15:0] product;
    logic [7:0] rd_mux;

    // ****************
    // link crossing
    // ****************
    xlf_serial_link u_link (
        .scl_clk_in(scl_clk_in),
        .frame_rst_in(frame_rst_r),
        .sda_in(sda_in),
        .dev_addr_in(DEV_ADDR),
        .rd_byte_in(rd_byte_r),
        .sda_oe_out(link_sda_oe),
        .wr_tgl_out(link_wr_tgl),
        .wr_byte_out(link_wr_byte),
        .wr_ptr_out(link_wr_ptr),
        .rd_tgl_out(link_rd_tgl)
    );

    // open drain: the line is only ever pulled low
    assign sda_oe_out = link_sda_oe;

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            sda_out <= 1'b0;
        else
            sda_out <= 1'b0;
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            {scl_m_r, scl_s_r, scl_d_r} <= 3'b111;
            {sda_m_r, sda_s_r, sda_d_r} <= 3'b111;
            {wr_tgl_m_r, wr_tgl_s_r, wr_tgl_d_r} <= 3'b000;
            {rd_tgl_m_r, rd_tgl_s_r, rd_tgl_d_r} <= 3'b000;
        end
        else
        begin
            scl_m_r <= scl_clk_in;
            scl_s_r <= scl_m_r;
            scl_d_r <= scl_s_r;
            sda_m_r <= sda_in;
            sda_s_r <= sda_m_r;
            sda_d_r <= sda_s_r;
            wr_tgl_m_r <= link_wr_tgl;
            wr_tgl_s_r <= wr_tgl_m_r;
            wr_tgl_d_r <= wr_tgl_s_r;
            rd_tgl_m_r <= link_rd_tgl;
            rd_tgl_s_r <= rd_tgl_m_r;
            rd_tgl_d_r <= rd_tgl_s_r;
        end
    end

    // start or stop holds the link engine in reset until the clock drops
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            frame_rst_r <= 1'b1;
        else if (scl_s_r && scl_d_r && (sda_s_r != sda_d_r))
            frame_rst_r <= 1'b1;
        else if (!scl_s_r)
            frame_rst_r <= 1'b0;
    end

    // byte is stable for a whole byte time after its toggle
    // a frame reset clears the link toggles; that edge is not a byte
    assign wr_evt = (wr_tgl_s_r != wr_tgl_d_r) && !frame_rst_r;
    assign rd_evt = (rd_tgl_s_r != rd_tgl_d_r) && !frame_rst_r;
    assign reg_wr = wr_evt && !link_wr_ptr;

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            ptr_r <= XLF_RESET_BYTE;
        else if (wr_evt && link_wr_ptr)
            ptr_r <= link_wr_byte;
        else if (reg_wr || rd_evt)
            ptr_r <= ptr_r + 8'h01;
    end

    // ****************
    // register file
    // ****************
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            loop_r <= XLF_RESET_BYTE;
            frac0_r <= XLF_RESET_BYTE;
            frac1_r <= XLF_RESET_BYTE;
            frac2_r <= XLF_RESET_BYTE;
            intlo_r <= XLF_RESET_BYTE;
            inthi_r <= XLF_RESET_BYTE;
            hslo_r <= XLF_RESET_BYTE;
            divhi_r <= XLF_RESET_BYTE;
        end
        else if (reg_wr)
        begin
            case (ptr_r)
                XLF_ADDR_LOOP: loop_r <= link_wr_byte;
                XLF_ADDR_FRAC0: frac0_r <= link_wr_byte;
                XLF_ADDR_FRAC1: frac1_r <= link_wr_byte;
                XLF_ADDR_FRAC2: frac2_r <= link_wr_byte;
                XLF_ADDR_INTLO: intlo_r <= link_wr_byte;
                XLF_ADDR_INTHI: inthi_r <= link_wr_byte;
                XLF_ADDR_HSLO: hslo_r <= link_wr_byte;
                XLF_ADDR_DIVHI: divhi_r <= link_wr_byte;
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            oe_r <= 1'b0;
        else if (reg_wr && ptr_r == XLF_ADDR_CTRL)
            oe_r <= link_wr_byte[XLF_CTRL_OE_BIT];
    end

    always_comb
    begin
        case (ptr_r)
            XLF_ADDR_LOOP: rd_mux = loop_r;
            XLF_ADDR_FRAC0: rd_mux = frac0_r;
            XLF_ADDR_FRAC1: rd_mux = frac1_r;
            XLF_ADDR_FRAC2: rd_mux = frac2_r;
            XLF_ADDR_INTLO: rd_mux = intlo_r;
            XLF_ADDR_INTHI: rd_mux = inthi_r;
            XLF_ADDR_HSLO: rd_mux = hslo_r;
            XLF_ADDR_DIVHI: rd_mux = divhi_r;
            XLF_ADDR_FLOOR: rd_mux = PRODUCT_FLOOR;
            XLF_ADDR_CEIL: rd_mux = PRODUCT_CEIL;
            // calibrate bit always reads zero
            XLF_ADDR_CTRL: rd_mux = 8'(oe_r) << XLF_CTRL_OE_BIT;
            default: rd_mux = XLF_RESET_BYTE;
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            rd_byte_r <= XLF_RESET_BYTE;
        else
            rd_byte_r <= rd_mux;
    end

    // ****************
    // active synthesizer settings
    // ****************
    // lower multiplier bytes stay staged until the top byte lands
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            m_int_out <= 9'h000;
            m_frac_out <= 29'h0;
        end
        else if (reg_wr && ptr_r == XLF_ADDR_INTHI)
        begin
            m_int_out <= {link_wr_byte[5:0], intlo_r[7:5]};
            m_frac_out <= {intlo_r[4:0], frac2_r, frac1_r, frac0_r};
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            high_speed_divider_out <= 10'h000;
            low_speed_ratio_out <= 6'h01;
            loop_comp_first_out <= 4'h0;
            loop_comp_second_out <= 4'h0;
        end
        else
        begin
            high_speed_divider_out <= {divhi_r[1:0], hslo_r};
            low_speed_ratio_out <= xlf_ls_ratio(divhi_r[7:5]);
            loop_comp_first_out <= loop_r[7:4];
            loop_comp_second_out <= loop_r[3:0];
        end
    end

    // ****************
    // calibration and output gate
    // ****************
    // only the calibrate bit starts a recenter; no change detection
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            cal_cnt_r <= 32'h0;
        else if (reg_wr && ptr_r == XLF_ADDR_CTRL && link_wr_byte[XLF_CTRL_CAL_BIT])
            cal_cnt_r <= 32'(SETTLE_CYCLES);
        else if (cal_cnt_r != 32'h0)
            cal_cnt_r <= cal_cnt_r - 32'h1;
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            calibrating_out <= 1'b0;
        else
            calibrating_out <= (cal_cnt_r > 32'h1) ||
                (reg_wr && ptr_r == XLF_ADDR_CTRL && link_wr_byte[XLF_CTRL_CAL_BIT]);
    end

    assign product = 16'(high_speed_divider_out) * 16'(low_speed_ratio_out);

    // settings out of the allowed band force the output off
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            clk_enable_out <= 1'b0;
        else
            clk_enable_out <= oe_r && xlf_in_band(product);
    end

    // ****************
    // checks
    // ****************
    sequence s_cal_write;
        reg_wr && ptr_r == XLF_ADDR_CTRL && link_wr_byte[XLF_CTRL_CAL_BIT];
    endsequence

    property p_cal_starts;
        @(posedge ref_clk_in) disable iff (rst_in) s_cal_write |=> calibrating_out;
    endproperty
    a_cal_starts: assert property (p_cal_starts) else $error("calibration did not start");

    property p_cal_reads_zero;
        @(posedge ref_clk_in) disable iff (rst_in) ptr_r == XLF_ADDR_CTRL |=> !rd_byte_r[XLF_CTRL_CAL_BIT];
    endproperty
    a_cal_reads_zero: assert property (p_cal_reads_zero) else $error("calibrate bit read as one");

    property p_no_self_cal;
        @(posedge ref_clk_in) disable iff (rst_in) !calibrating_out
            && !(reg_wr && ptr_r == XLF_ADDR_CTRL && link_wr_byte[XLF_CTRL_CAL_BIT])
            |=> !calibrating_out;
    endproperty
    a_no_self_cal: assert property (p_no_self_cal) else $error("calibration began unasked");

    // busy stretch counted apart from the settle counter; a restart begins a new stretch
    logic [31:0] busy_len_r;

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            busy_len_r <= 32'h0;
        else if (!calibrating_out || (reg_wr && ptr_r == XLF_ADDR_CTRL && link_wr_byte[XLF_CTRL_CAL_BIT]))
            busy_len_r <= 32'h0;
        else
            busy_len_r <= busy_len_r + 32'h1;
    end

    property p_settle_bound;
        @(posedge ref_clk_in) disable iff (rst_in) busy_len_r <= 32'(SETTLE_CYCLES);
    endproperty
    a_settle_bound: assert property (p_settle_bound) else $error("settling exceeds limit");

    property p_band_gate;
        @(posedge ref_clk_in) disable iff (rst_in) !xlf_in_band(product) |=> !clk_enable_out;
    endproperty
    a_band_gate: assert property (p_band_gate) else $error("output on outside product band");

    property p_ls_zero;
        @(posedge ref_clk_in) disable iff (rst_in) divhi_r[7:5] == 3'h0 |=> low_speed_ratio_out == 6'h01;
    endproperty
    a_ls_zero: assert property (p_ls_zero) else $error("code zero not divide by one");

    property p_ls_pow;
        @(posedge ref_clk_in) disable iff (rst_in) divhi_r[7:5] <= XLF_LS_MAX_CODE
            |=> low_speed_ratio_out == (6'h01 << $past(divhi_r[7:5]));
    endproperty
    a_ls_pow: assert property (p_ls_pow) else $error("low-speed ratio wrong");

    property p_m_held;
        @(posedge ref_clk_in) disable iff (rst_in) !(reg_wr && ptr_r == XLF_ADDR_INTHI) |=> $stable(m_frac_out);
    endproperty
    a_m_held: assert property (p_m_held) else $error("multiplier changed without top write");

    property p_m_apply;
        @(posedge ref_clk_in) disable iff (rst_in) reg_wr && ptr_r == XLF_ADDR_INTHI
            |=> m_int_out[8:3] == $past(link_wr_byte[5:0]);
    endproperty
    a_m_apply: assert property (p_m_apply) else $error("multiplier not applied");

    property p_loop_fields;
        @(posedge ref_clk_in) disable iff (rst_in) reg_wr && ptr_r == XLF_ADDR_LOOP
            |=> ##1 loop_comp_first_out == $past(link_wr_byte[7:4], 2);
    endproperty
    a_loop_fields: assert property (p_loop_fields) else $error("loop value field wrong");
endmodule : xlf_reprogram_ctrl

// ==== rtl/xlf_pkg.sv ====
// constants shared by the reprogramming control block
package xlf_pkg;
    // ****************
    // register map
    // ****************
    localparam logic [7:0] XLF_ADDR_LOOP = 8'h00;
    localparam logic [7:0] XLF_ADDR_FRAC0 = 8'h05;
    localparam logic [7:0] XLF_ADDR_FRAC1 = 8'h06;
    localparam logic [7:0] XLF_ADDR_FRAC2 = 8'h07;
    localparam logic [7:0] XLF_ADDR_INTLO = 8'h08;
    localparam logic [7:0] XLF_ADDR_INTHI = 8'h09;
    localparam logic [7:0] XLF_ADDR_HSLO = 8'h0a;
    localparam logic [7:0] XLF_ADDR_DIVHI = 8'h0b;
    localparam logic [7:0] XLF_ADDR_FLOOR = 8'h30;
    localparam logic [7:0] XLF_ADDR_CEIL = 8'h31;
    localparam logic [7:0] XLF_ADDR_CTRL = 8'h84;
    // ****************
    // field positions
    // ****************
    localparam int XLF_CTRL_OE_BIT = 2;
    localparam int XLF_CTRL_CAL_BIT = 0;
    localparam logic [2:0] XLF_LS_MAX_CODE = 3'h5;
    localparam logic [7:0] XLF_RESET_BYTE = 8'h00;
    localparam logic [3:0] XLF_BIT_ACK = 4'h8;
    localparam logic [3:0] XLF_BIT_LAST = 4'h7;
    // ****************
    // timing
    // ****************
    localparam int XLF_CLK_PERIOD_PS = 25000;
    localparam int XLF_SETTLE_MS = 10;
    // divide first: the plain product overflows a 32-bit int
    localparam int XLF_SETTLE_CYCLES = XLF_SETTLE_MS * (1000000000 / XLF_CLK_PERIOD_PS);
    localparam int XLF_FLOOR_DEFAULT = 20;
    localparam int XLF_CEIL_DEFAULT = 250;
    localparam logic [6:0] XLF_DEV_ADDR_DEFAULT = 7'h55;
endpackage : xlf_pkg

// ==== rtl/xlf_serial_link.sv ====
// serial link bit engine, clocked by the host's serial clock
`timescale 1ns/1ps
module xlf_serial_link
    import xlf_pkg::*;
(
    input wire logic scl_clk_in,          // serial clock from host
    input wire logic frame_rst_in,        // async reset between frames
    input wire logic sda_in,              // data line level
    input wire logic [6:0] dev_addr_in,   // device address
    input wire logic [7:0] rd_byte_in,    // byte to send, held stable
    output logic sda_oe_out,              // pull data line low
    output logic wr_tgl_out,              // toggles per received data byte
    output logic [7:0] wr_byte_out,       // received data byte
    output logic wr_ptr_out,              // received byte is the pointer
    output logic rd_tgl_out               // toggles per byte loaded to send
);
    logic [3:0] bit_cnt_r;
    logic [6:0] shift_r;
    logic first_r;
    logic ptr_next_r;
    logic addr_ok_r;
    logic rw_r;
    logic nack_r;
    logic [7:0] tx_r;
    logic [7:0] rx_byte;

    assign rx_byte = {shift_r, sda_in};

    // ****************
    // receive on rising edge
    // ****************
    always_ff @(posedge scl_clk_in or posedge frame_rst_in)
    begin
        if (frame_rst_in)
        begin
            bit_cnt_r <= 4'h0;
            shift_r <= 7'h00;
            first_r <= 1'b1;
            ptr_next_r <= 1'b1;
            addr_ok_r <= 1'b0;
            rw_r <= 1'b0;
            nack_r <= 1'b0;
            wr_tgl_out <= 1'b0;
            wr_byte_out <= XLF_RESET_BYTE;
            wr_ptr_out <= 1'b0;
        end
        else if (bit_cnt_r == XLF_BIT_ACK)
        begin
            bit_cnt_r <= 4'h0;
            first_r <= 1'b0;
            // host nack ends a read burst
            if (rw_r && !first_r && sda_in)
                nack_r <= 1'b1;
        end
        else
        begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            shift_r <= rx_byte[6:0];
            if (bit_cnt_r == XLF_BIT_LAST)
            begin
                if (first_r)
                begin
                    addr_ok_r <= (rx_byte[7:1] == dev_addr_in);
                    rw_r <= rx_byte[0];
                end
                else if (addr_ok_r && !rw_r)
                begin
                    wr_byte_out <= rx_byte;
                    wr_ptr_out <= ptr_next_r;
                    ptr_next_r <= 1'b0;
                    wr_tgl_out <= ~wr_tgl_out;
                end
            end
        end
    end

    // ****************
    // drive on falling edge
    // ****************
    always_ff @(negedge scl_clk_in or posedge frame_rst_in)
    begin
        if (frame_rst_in)
        begin
            sda_oe_out <= 1'b0;
            tx_r <= XLF_RESET_BYTE;
            rd_tgl_out <= 1'b0;
        end
        else if (bit_cnt_r == XLF_BIT_ACK)
            // address match was latched on the eighth bit; the shift register has moved on since
            sda_oe_out <= addr_ok_r && (first_r || !rw_r);
        else if (addr_ok_r && rw_r && !first_r && !nack_r)
        begin
            if (bit_cnt_r == 4'h0)
            begin
                tx_r <= rd_byte_in;
                sda_oe_out <= ~rd_byte_in[7];
                rd_tgl_out <= ~rd_tgl_out;
            end
            else
                sda_oe_out <= ~tx_r[3'(XLF_BIT_LAST - bit_cnt_r)];
        end
        else
            sda_oe_out <= 1'b0;
    end
endmodule : xlf_serial_link

// ==== verif/xlf_i2c_host.sv ====
// two-wire serial host model for the register port
`timescale 1ns/1ps
module xlf_i2c_host
(
    input wire logic sda_in,   // resolved data line level
    output logic scl_out,      // serial clock, still between frames
    output logic sda_low_out   // high while the host pulls data low
);
    initial
    begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // ****************
    // bit level
    // ****************
    // data moves mid low phase; 32 ns halves give the 64 ns link period
    task automatic put_bit(input logic b, output logic s);
        #16 sda_low_out = !b;
        #16 scl_out = 1'b1;
        #16 s = sda_in;
        #16 scl_out = 1'b0;
    endtask : put_bit
    task automatic put_byte(input logic [7:0] b, input logic ack_in, output logic [7:0] got, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            put_bit(b[i], s);
            got[i] = s;
        end
        put_bit(ack_in, ack);
    endtask : put_byte
    // start and stop phases are long so the edge detector sees them
    // and the bit engine is out of reset before the first rising edge
    task automatic start();
        #16 sda_low_out = 1'b0;
        #16 scl_out = 1'b1;
        #100 sda_low_out = 1'b1;
        #150 scl_out = 1'b0;
        #100;
    endtask : start
    task automatic stop();
        #16 sda_low_out = 1'b1;
        #16 scl_out = 1'b1;
        #100 sda_low_out = 1'b0;
        #200;
    endtask : stop
    // ****************
    // register frames
    // ****************
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, output logic ack);
        logic [7:0] g;
        logic k0;
        logic k1;
        logic k2;
        start();
        put_byte({dev, 1'b0}, 1'b1, g, k0);
        put_byte(a, 1'b1, g, k1);
        put_byte(d, 1'b1, g, k2);
        stop();
        ack = !k0 && !k1 && !k2;
    endtask : write_reg
    task automatic read_reg(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d);
        logic [7:0] g;
        logic k;
        start();
        put_byte({dev, 1'b0}, 1'b1, g, k);
        put_byte(a, 1'b1, g, k);
        start();
        put_byte({dev, 1'b1}, 1'b1, g, k);
        put_byte(8'hff, 1'b1, d, k);
        stop();
    endtask : read_reg
endmodule : xlf_i2c_host

// ==== verif/xlf_reprogram_ctrl_tb.sv ====
// self-checking bench for the reprogramming control block
`timescale 1ns/1ps
module xlf_reprogram_ctrl_tb;
    import xlf_pkg::*;
    localparam int SETTLE = 50;
    localparam logic [6:0] DEV = XLF_DEV_ADDR_DEFAULT;
    // {ls code, 3'b0, hs} pairs around the product band edges
    localparam logic [15:0] BOUND [6] = '{16'h200a, 16'h0012, 16'h00fa, 16'h00fc, 16'h207e, 16'h207c};
    // {address, data} of a full large-change load, upper integer after 5-8
    localparam logic [15:0] LARGE [8] = '{16'h0033, 16'h0557, 16'h0645, 16'h07a4, 16'h0842, 16'h0905,
        16'h0a2a, 16'h0b00};
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic scl, host_low, sda_wire, sda_out, sda_oe_out, calibrating_out, clk_enable_out;
    logic [8:0] m_int_out;
    logic [28:0] m_frac_out;
    logic [9:0] high_speed_divider_out;
    logic [5:0] low_speed_ratio_out;
    logic [3:0] loop_comp_first_out, loop_comp_second_out;
    int fail_count = 0;
    int comparisons = 0;
    logic [7:0] regs [256];
    logic [8:0] exp_int = '0;
    logic [28:0] exp_frac = '0;
    always #12.5 ref_clk_in = !ref_clk_in;
    // open-drain data line with pull-up
    assign sda_wire = !(host_low || (sda_oe_out && !sda_out));
    xlf_reprogram_ctrl #(.SETTLE_CYCLES(SETTLE)) uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .scl_clk_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
        .m_int_out(m_int_out), .m_frac_out(m_frac_out), .high_speed_divider_out(high_speed_divider_out),
        .low_speed_ratio_out(low_speed_ratio_out), .loop_comp_first_out(loop_comp_first_out),
        .loop_comp_second_out(loop_comp_second_out), .calibrating_out(calibrating_out),
        .clk_enable_out(clk_enable_out));
    xlf_i2c_host host (.sda_in(sda_wire), .scl_out(scl), .sda_low_out(host_low));
    // ****************
    // checking and model
    // ****************
    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    function automatic logic [7:0] model_rd(input logic [7:0] a);
        if (a == XLF_ADDR_LOOP || (a >= XLF_ADDR_FRAC0 && a <= XLF_ADDR_DIVHI))
            return regs[a];
        if (a == XLF_ADDR_FLOOR)
            return 8'(XLF_FLOOR_DEFAULT);
        if (a == XLF_ADDR_CEIL)
            return 8'(XLF_CEIL_DEFAULT);
        if (a == XLF_ADDR_CTRL)
            return regs[a] & 8'h04;
        return 8'h00;
    endfunction : model_rd
    task automatic check_reg(input logic [7:0] a);
        logic [7:0] d;
        host.read_reg(DEV, a, d);
        check(32'(d), 32'(model_rd(a)));
    endtask : check_reg
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ack;
        host.write_reg(DEV, a, d, ack);
        check(32'(ack), 32'h1);
        // read-only limits are not stored
        if (a == XLF_ADDR_LOOP || (a >= XLF_ADDR_FRAC0 && a <= XLF_ADDR_DIVHI) || a == XLF_ADDR_CTRL)
            regs[a] = d;
        if (a == XLF_ADDR_INTHI)
        begin
            exp_int = {regs[9][5:0], regs[8][7:5]};
            exp_frac = {regs[8][4:0], regs[7], regs[6], regs[5]};
        end
        repeat (4) @(posedge ref_clk_in);
    endtask : wr
    task automatic check_outs();
        int hs;
        int code;
        int ratio;
        hs = {regs[11][1:0], regs[10]};
        code = regs[11][7:5];
        ratio = (code > 5) ? 32 : (1 << code);
        check(32'(m_int_out), 32'(exp_int));
        check(32'(m_frac_out), 32'(exp_frac));
        check(32'(high_speed_divider_out), 32'(hs));
        check(32'(low_speed_ratio_out), 32'(ratio));
        check(32'(loop_comp_first_out), 32'(regs[0][7:4]));
        check(32'(loop_comp_second_out), 32'(regs[0][3:0]));
        check(32'(clk_enable_out), 32'(regs[132][2] && hs * ratio >= XLF_FLOOR_DEFAULT
            && hs * ratio <= XLF_CEIL_DEFAULT));
    endtask : check_outs
    // ****************
    // scenarios
    // ****************
    task automatic run();
        logic ack;
        int n;
        for (int a = 5; a <= 8; a++)
        begin
            wr(8'(a), 8'($urandom));
            check_outs();
        end
        wr(XLF_ADDR_INTHI, 8'($urandom));
        check_outs();
        wr(XLF_ADDR_LOOP, 8'($urandom));
        check_outs();
        wr(XLF_ADDR_CTRL, 8'h04);
        for (int c = 0; c < 8; c++)
        begin
            wr(XLF_ADDR_HSLO, 8'($urandom) & 8'hfe);
            wr(XLF_ADDR_DIVHI, {3'(c), 5'h00});
            check_outs();
        end
        foreach (BOUND[i])
        begin
            wr(XLF_ADDR_HSLO, BOUND[i][7:0]);
            wr(XLF_ADDR_DIVHI, {BOUND[i][15:13], 3'h0, BOUND[i][9:8]});
            check_outs();
        end
        wr(XLF_ADDR_CTRL, 8'h05);
        check_outs();
        wr(XLF_ADDR_FLOOR, 8'h11);
        foreach (LARGE[i])
            check_reg(LARGE[i][15:8]);
        check_reg(XLF_ADDR_FLOOR);
        check_reg(XLF_ADDR_CEIL);
        check_reg(XLF_ADDR_CTRL);
        check_reg(8'h40);
        host.write_reg(7'h2a, XLF_ADDR_LOOP, 8'h77, ack);
        check(32'(ack), 32'h0);
        check_reg(XLF_ADDR_LOOP);
        // full large change: gate, load, calibrate, settle, ungate
        wr(XLF_ADDR_CTRL, 8'h00);
        foreach (LARGE[i])
            wr(LARGE[i][15:8], LARGE[i][7:0]);
        check(32'(calibrating_out), 32'h0);
        check_outs();
        wr(XLF_ADDR_CTRL, 8'h01);
        check(32'(calibrating_out), 32'h1);
        n = 0;
        while (calibrating_out !== 1'b0 && n < SETTLE)
        begin
            @(posedge ref_clk_in);
            n++;
        end
        // settling past the bound is a hang as well as a mismatch
        if (n >= SETTLE)
        begin
            fail_count++;
            return;
        end
        check(32'(calibrating_out), 32'h0);
        check_reg(XLF_ADDR_CTRL);
        wr(XLF_ADDR_CTRL, 8'h04);
        check_outs();
    endtask : run
    initial
    begin
        regs = '{default: 8'h00};
        void'($urandom(32'h7d3001fa));
        repeat (20) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        check_outs();
        check(32'(calibrating_out), 32'h0);
        run();
        print_verdict();
    end
endmodule : xlf_reprogram_ctrl_tb
